// ==== field_sensor_pkg.sv ====
package field_sensor_pkg;

    // ------------------------------------------------------------------
    // Parameter memory addresses
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CONFIG    = 4'h0;
    localparam logic [3:0] ADDR_SENS      = 4'h1;
    localparam logic [3:0] ADDR_QUIESCENT = 4'h2;
    localparam logic [3:0] ADDR_CLAMP_LO  = 4'h3;
    localparam logic [3:0] ADDR_CLAMP_HI  = 4'h4;
    localparam logic [3:0] ADDR_TEMPCO    = 4'h5;
    localparam logic [3:0] ADDR_LOCK      = 4'h6;
    localparam logic [3:0] ADDR_TRIM_OSC  = 4'h7;
    localparam logic [3:0] ADDR_TRIM_ADC  = 4'h8;
    localparam logic [3:0] ADDR_READOUT   = 4'h9;
    localparam logic [3:0] ADDR_GP_BASE   = 4'hA;
    localparam int         RED_WORDS      = 9;
    localparam int         GP_BLOCKS      = 4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_GP_EN_BIT   = 0;
    localparam int CFG_RANGE_LSB   = 2;
    localparam int CFG_FILTER_BIT  = 4;
    localparam int CFG_PROTOCOL_BIT_PERIOD_BIT = 5;
    localparam int TC_LIN_LSB      = 0;
    localparam int TC_QUAD_LSB     = 5;
    localparam int TC_GROUP_LSB    = 8;
    localparam int LOCK_BIT        = 0;
    localparam int SENS_FRAC       = 11;

    // ------------------------------------------------------------------
    // Reset and factory values
    // ------------------------------------------------------------------
    localparam logic [15:0] CONFIG_INIT    = 16'h0000;
    localparam logic [15:0] SENS_INIT      = 16'h0400;
    localparam logic [15:0] QUIESCENT_INIT = 16'h2000;
    localparam logic [15:0] CLAMP_LO_INIT  = 16'h0000;
    localparam logic [15:0] CLAMP_HI_INIT  = 16'h3FFF;
    localparam logic [15:0] TEMPCO_INIT    = 16'h012F;
    localparam logic [13:0] READOUT_MAX    = 14'h3FFF;
    localparam logic [4:0]  TC_LIN_ZERO    = 5'h0F;
    localparam logic [2:0]  TC_QUAD_ZERO   = 3'h1;

    // ------------------------------------------------------------------
    // Programming link timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 250;
    localparam int BIT_SHORT_US   = 1750;
    localparam int BIT_LONG_US    = 3500;
    localparam int BIT_SHORT_CYC  = BIT_SHORT_US * CLK_MHZ;
    localparam int BIT_LONG_CYC   = BIT_LONG_US * CLK_MHZ;
    localparam int HDR_BITS       = 5;
    localparam int FRAME_WR_BITS  = 21;
    localparam int REPLY_BITS     = 16;

endpackage

// ==== dsp_if.sv ====
`timescale 1ns/1ps
interface dsp_if;
    logic signed [15:0] sample;
    logic               sample_valid;
    logic               corner_fast;
    logic signed [15:0] filtered;
    logic               filtered_valid;

    modport filt (
        input  sample,
        input  sample_valid,
        input  corner_fast,
        output filtered,
        output filtered_valid
    );
    modport path (
        output sample,
        output sample_valid,
        output corner_fast,
        input  filtered,
        input  filtered_valid
    );
endinterface

// ==== field_lowpass.sv ====
`timescale 1ns/1ps
module field_lowpass (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Sample stream
    dsp_if.filt       dsp
);

    // ------------------------------------------------------------------
    // First-order IIR, shift selects the corner
    // ------------------------------------------------------------------
    // Extra fraction bits keep small steps from being lost to truncation.
    logic signed [23:0] acc_reg;
    logic signed [23:0] step;
    logic signed [23:0] diff;

    always_comb begin
        diff = {dsp.sample, 8'h00} - acc_reg;
        step = dsp.corner_fast ? (diff >>> 5) : (diff >>> 6);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_reg             <= 24'h00_0000;
            dsp.filtered_valid  <= 1'b0;
        end else begin
            dsp.filtered_valid <= dsp.sample_valid;
            if (dsp.sample_valid) begin
                acc_reg <= acc_reg + step;
            end
        end
    end

    assign dsp.filtered = acc_reg[23:8];

endmodule

// ==== field_sensor_dsp_path.sv ====
`timescale 1ns/1ps
module field_sensor_dsp_path #(
    parameter int BIT_SHORT = field_sensor_pkg::BIT_SHORT_CYC,
    parameter int BIT_LONG  = field_sensor_pkg::BIT_LONG_CYC,
    parameter logic [15:0] OSC_TRIM = 16'h0080,
    parameter logic [15:0] ADC_TRIM = 16'h0000
) (
    // Clock and power-on reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Converter side
    input  wire logic signed [15:0] sample,
    input  wire logic              sample_valid,
    input  wire logic signed [7:0] temperature,
    output logic             [1:0] adc_range,
    output logic            [15:0] osc_trim,
    output logic            [15:0] adc_trim,
    // Supply monitor
    input  wire logic              supply_in_band,
    input  wire logic              supply_high,
    // Output pin
    input  wire logic              out_pin_in,
    output logic                   out_pin_out,
    output logic                   out_pin_oe_n,
    output logic                   analog_out_en,
    output logic            [13:0] out_code,
    // Production
    input  wire logic              factory_init
);

    // ------------------------------------------------------------------
    // Parameter memory
    // ------------------------------------------------------------------
    // Three copies per signal-path word, voted on read. The store blocks
    // are single copies: a flipped bit there cannot upset the output.
    logic [15:0] red_mem [field_sensor_pkg::RED_WORDS][3];
    logic [12:0] gp_mem  [field_sensor_pkg::GP_BLOCKS];

    function automatic logic [15:0] vote(input logic [3:0] a);
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
        x = red_mem[a][0];
        y = red_mem[a][1];
        z = red_mem[a][2];
        return (x & y) | (y & z) | (x & z);
    endfunction

    logic [15:0] cfg_w;
    logic [15:0] sens_w;
    logic [15:0] voq_w;
    logic [15:0] clo_w;
    logic [15:0] chi_w;
    logic [15:0] tc_w;
    logic [15:0] lock_w;

    always_comb begin
        cfg_w  = vote(field_sensor_pkg::ADDR_CONFIG);
        sens_w = vote(field_sensor_pkg::ADDR_SENS);
        voq_w  = vote(field_sensor_pkg::ADDR_QUIESCENT);
        clo_w  = vote(field_sensor_pkg::ADDR_CLAMP_LO);
        chi_w  = vote(field_sensor_pkg::ADDR_CLAMP_HI);
        tc_w   = vote(field_sensor_pkg::ADDR_TEMPCO);
        lock_w = vote(field_sensor_pkg::ADDR_LOCK);
    end

    // ------------------------------------------------------------------
    // Lock capture
    // ------------------------------------------------------------------
    // The lock cell is only looked at once per power-up, so a lock written
    // now leaves the link open until the supply has been cycled.
    logic boot_reg;
    logic lock_active_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_reg        <= 1'b1;
            lock_active_reg <= 1'b0;
        end else if (boot_reg) begin
            boot_reg        <= 1'b0;
            lock_active_reg <= lock_w[field_sensor_pkg::LOCK_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Signal path
    // ------------------------------------------------------------------
    dsp_if dsp ();

    assign dsp.sample       = sample;
    assign dsp.sample_valid = sample_valid;
    assign dsp.corner_fast  = cfg_w[field_sensor_pkg::CFG_FILTER_BIT];

    field_lowpass u_lowpass (
        .clk (clk),
        .rst (rst),
        .dsp (dsp.filt)
    );

    logic signed [15:0] coef;
    logic signed [31:0] tc_term;
    logic signed [31:0] comp_wide;
    logic signed [31:0] prod;
    logic signed [31:0] prod_reg;
    logic               prod_valid_reg;
    logic signed [32:0] sum;
    logic        [13:0] sat;
    logic        [13:0] lim;
    logic        [13:0] readout_reg;

    always_comb begin
        coef = 16'(signed'({11'h000, tc_w[field_sensor_pkg::TC_LIN_LSB +: 5]})
             - signed'({11'h000, field_sensor_pkg::TC_LIN_ZERO}))
             + 16'(signed'({13'h0000, tc_w[field_sensor_pkg::TC_QUAD_LSB +: 3]})
             - signed'({13'h0000, field_sensor_pkg::TC_QUAD_ZERO}))
             * 16'(temperature)
             + 16'(signed'({14'h0000, tc_w[field_sensor_pkg::TC_GROUP_LSB +: 2]})
             - 16'sh0001) * 16'sh0010;
        tc_term   = (32'(dsp.filtered) * 32'(coef) * 32'(temperature)) >>> 14;
        comp_wide = 32'(dsp.filtered) + tc_term;
        prod      = (comp_wide * 32'(signed'(sens_w)))
                    >>> field_sensor_pkg::SENS_FRAC;
        sum = 33'(prod_reg) + 33'(signed'(voq_w));
        if (sum < 0) begin
            sat = 14'h0000;
        end else if (sum > 33'(field_sensor_pkg::READOUT_MAX)) begin
            sat = field_sensor_pkg::READOUT_MAX;
        end else begin
            sat = sum[13:0];
        end
        lim = sat;
        if (lim < clo_w[13:0]) begin
            lim = clo_w[13:0];
        end
        if (lim > chi_w[13:0]) begin
            lim = chi_w[13:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prod_reg       <= 32'h0000_0000;
            prod_valid_reg <= 1'b0;
            readout_reg    <= 14'h0000;
        end else begin
            prod_valid_reg <= dsp.filtered_valid;
            if (dsp.filtered_valid) begin
                prod_reg <= prod;
            end
            if (prod_valid_reg) begin
                readout_reg <= lim;
            end
        end
    end

    // ------------------------------------------------------------------
    // Programming link
    // ------------------------------------------------------------------
    // Frame: write flag, four address bits, then sixteen data bits on a
    // write. Each bit is sampled in the middle of its period.
    typedef enum logic [1:0] {LINK_IDLE, LINK_RECV, LINK_REPLY} link_t;

    link_t       state_reg;
    logic [19:0] tick_reg;
    logic [4:0]  bit_reg;
    logic [20:0] shift_reg;
    logic [15:0] reply_reg;
    logic        sel_reg;
    logic [19:0] period;
    logic [4:0]  frame_len;
    logic        frame_done;
    logic        wr_now;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    always_comb begin
        period = cfg_w[field_sensor_pkg::CFG_PROTOCOL_BIT_PERIOD_BIT]
               ? 20'(BIT_SHORT) : 20'(BIT_LONG);
        frame_len = shift_reg[20]
                  ? 5'(field_sensor_pkg::FRAME_WR_BITS)
                  : 5'(field_sensor_pkg::HDR_BITS);
        frame_done = state_reg == LINK_RECV && bit_reg == frame_len;
        addr  = shift_reg[19:16];
        wdata = shift_reg[15:0];
        wr_now = frame_done && shift_reg[20] && sel_reg
               && !lock_active_reg;
        if (addr >= field_sensor_pkg::ADDR_GP_BASE) begin
            rdata = {3'h0, gp_mem[2'(addr - field_sensor_pkg::ADDR_GP_BASE)]};
        end else if (addr == field_sensor_pkg::ADDR_READOUT) begin
            rdata = {2'h0, readout_reg};
        end else begin
            rdata = vote(addr);
        end
    end

    // Frame bits are written MSB first straight into place from bit 20 down,
    // so the header always sits in bits 20:16.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= LINK_IDLE;
            tick_reg  <= 20'h0_0000;
            bit_reg   <= 5'h00;
            shift_reg <= 21'h00_0000;
            reply_reg <= 16'h0000;
            sel_reg   <= 1'b0;
        end else begin
            unique case (state_reg)
                LINK_IDLE: begin
                    if (!supply_in_band && supply_high) begin
                        state_reg <= LINK_RECV;
                        sel_reg   <= out_pin_in;
                        tick_reg  <= period >> 1;
                        bit_reg   <= 5'h00;
                    end
                end
                LINK_RECV: begin
                    if (frame_done) begin
                        if (!shift_reg[20] && sel_reg && !lock_active_reg) begin
                            state_reg <= LINK_REPLY;
                            reply_reg <= rdata;
                            tick_reg  <= period - 20'h0_0001;
                            bit_reg   <= 5'h00;
                        end else begin
                            state_reg <= LINK_IDLE;
                        end
                    end else if (tick_reg == 20'h0_0000) begin
                        shift_reg[20 - bit_reg] <= supply_high;
                        bit_reg  <= bit_reg + 5'h01;
                        tick_reg <= period - 20'h0_0001;
                    end else begin
                        tick_reg <= tick_reg - 20'h0_0001;
                    end
                end
                LINK_REPLY: begin
                    if (tick_reg == 20'h0_0000) begin
                        reply_reg <= {reply_reg[14:0], 1'b0};
                        tick_reg  <= period - 20'h0_0001;
                        bit_reg   <= bit_reg + 5'h01;
                        if (bit_reg == 5'(field_sensor_pkg::REPLY_BITS - 1)) begin
                            state_reg <= LINK_IDLE;
                        end
                    end else begin
                        tick_reg <= tick_reg - 20'h0_0001;
                    end
                end
            endcase
        end
    end

    // Memory writes. Trim words only move on the production strobe.
    always_ff @(posedge clk) begin
        if (factory_init) begin
            for (int c = 0; c < 3; c++) begin
                red_mem[field_sensor_pkg::ADDR_CONFIG][c]    <= field_sensor_pkg::CONFIG_INIT;
                red_mem[field_sensor_pkg::ADDR_SENS][c]      <= field_sensor_pkg::SENS_INIT;
                red_mem[field_sensor_pkg::ADDR_QUIESCENT][c] <= field_sensor_pkg::QUIESCENT_INIT;
                red_mem[field_sensor_pkg::ADDR_CLAMP_LO][c]  <= field_sensor_pkg::CLAMP_LO_INIT;
                red_mem[field_sensor_pkg::ADDR_CLAMP_HI][c]  <= field_sensor_pkg::CLAMP_HI_INIT;
                red_mem[field_sensor_pkg::ADDR_TEMPCO][c]    <= field_sensor_pkg::TEMPCO_INIT;
                red_mem[field_sensor_pkg::ADDR_LOCK][c]      <= 16'h0000;
                red_mem[field_sensor_pkg::ADDR_TRIM_OSC][c]  <= OSC_TRIM;
                red_mem[field_sensor_pkg::ADDR_TRIM_ADC][c]  <= ADC_TRIM;
            end
            for (int g = 0; g < field_sensor_pkg::GP_BLOCKS; g++) begin
                gp_mem[g] <= 13'h0000;
            end
        end else if (wr_now) begin
            if (addr >= field_sensor_pkg::ADDR_GP_BASE) begin
                if (cfg_w[field_sensor_pkg::CFG_GP_EN_BIT]) begin
                    gp_mem[2'(addr - field_sensor_pkg::ADDR_GP_BASE)]
                        <= wdata[12:0];
                end
            end else if (addr < field_sensor_pkg::ADDR_TRIM_OSC) begin
                for (int c = 0; c < 3; c++) begin
                    red_mem[addr][c] <= wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_code      <= 14'h0000;
            analog_out_en <= 1'b0;
            out_pin_out   <= 1'b0;
            out_pin_oe_n  <= 1'b1;
            adc_range     <= 2'h0;
            osc_trim      <= 16'h0000;
            adc_trim      <= 16'h0000;
        end else begin
            out_code      <= readout_reg;
            analog_out_en <= state_reg == LINK_IDLE && supply_in_band
                             && !(supply_high && !supply_in_band);
            out_pin_oe_n  <= state_reg != LINK_REPLY;
            out_pin_out   <= state_reg == LINK_REPLY && reply_reg[15];
            adc_range     <= cfg_w[field_sensor_pkg::CFG_RANGE_LSB +: 2];
            osc_trim      <= vote(field_sensor_pkg::ADDR_TRIM_OSC);
            adc_trim      <= vote(field_sensor_pkg::ADDR_TRIM_ADC);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_readout_range;
        @(posedge clk) disable iff (rst)
        readout_reg <= field_sensor_pkg::READOUT_MAX;
    endproperty
    a_readout_range: assert property (p_readout_range)
        else $error("processed value above range");

    property p_window;
        @(posedge clk) disable iff (rst)
        prod_valid_reg && clo_w[13:0] <= chi_w[13:0]
        |=> readout_reg >= $past(clo_w[13:0])
            && readout_reg <= $past(chi_w[13:0]);
    endproperty
    a_window: assert property (p_window)
        else $error("output outside limit window");

    property p_analog_off;
        @(posedge clk) disable iff (rst)
        state_reg != LINK_IDLE |=> !analog_out_en;
    endproperty
    a_analog_off: assert property (p_analog_off)
        else $error("analog output on during exchange");

    property p_lock_blocks;
        @(posedge clk) disable iff (rst)
        lock_active_reg |-> !wr_now;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks)
        else $error("write taken while locked");

    property p_lock_sticky;
        @(posedge clk) disable iff (rst)
        lock_active_reg |=> lock_active_reg;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock released without power cycle");

    property p_unselected;
        @(posedge clk) disable iff (rst)
        state_reg == LINK_RECV && !sel_reg |-> !wr_now ##1 state_reg != LINK_REPLY;
    endproperty
    a_unselected: assert property (p_unselected)
        else $error("unselected device acted");

    property p_reply_drive;
        @(posedge clk) disable iff (rst)
        state_reg == LINK_REPLY |=> !out_pin_oe_n;
    endproperty
    a_reply_drive: assert property (p_reply_drive)
        else $error("reply not driven on pin");

    property p_filter_first;
        @(posedge clk) disable iff (rst)
        prod_valid_reg |-> $past(dsp.filtered_valid);
    endproperty
    a_filter_first: assert property (p_filter_first)
        else $error("sample bypassed the filter");

endmodule

// ==== prog_model.sv ====
`timescale 1ns/1ps
module prog_model (
    // Clock
    input  wire logic        clk,
    // Pin and supply
    input  wire logic        pin,
    input  wire logic        oe_n,
    output logic             in_band,
    output logic             high,
    output logic             sel,
    // Reply
    output logic             reply_stb,
    output logic      [15:0] reply_word
);
    logic [20:0] bits;

    initial begin
        in_band = 1'b1;
        high = 1'b0;
        sel = 1'b0;
        reply_stb = 1'b0;
        reply_word = 16'h0000;
    end

    // ----------------------------------------------------------
    // Frame
    // ----------------------------------------------------------
    // The supply returns to the band just after the last bit is sampled,
    // because the reply follows within a few cycles.
    task automatic frame(input logic wr, input logic [3:0] a,
                         input logic [15:0] d, input logic s, input int p);
        int n;
        bits = {wr, a, d};
        n = wr ? 21 : 5;
        @(posedge clk);
        #1;
        sel = s;
        in_band = 1'b0;
        high = 1'b1;
        @(posedge clk);
        for (int k = 0; k < n; k++) begin
            #1;
            high = bits[20 - k];
            repeat (k == 0 ? p - 1 : (k == n - 1 ? p / 2 + 2 : p)) @(posedge clk);
        end
        #1;
        in_band = 1'b1;
        high = 1'b0;
        if (!wr && s) begin
            for (int w = 0; w < 2 * p && oe_n; w++) @(posedge clk);
            repeat (p / 2) @(posedge clk);
            for (int i = 15; i >= 0; i--) begin
                reply_word[i] = pin;
                repeat (p) @(posedge clk);
            end
            reply_stb = 1'b1;
            @(posedge clk);
            #1;
            reply_stb = 1'b0;
        end
        sel = 1'b0;
        repeat (p) @(posedge clk);
        #1;
    endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    localparam int P = 80;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic signed [15:0] sample = 16'h0000;
    logic               sample_valid = 1'b0;
    logic signed [7:0]  temperature = 8'h00;
    logic               factory_init = 1'b0;
    logic               supply_in_band;
    logic               supply_high;
    logic               sel;
    logic               pin;
    logic               out_pin_out;
    logic               out_pin_oe_n;
    logic               analog_out_en;
    logic        [1:0]  adc_range;
    logic        [15:0] osc_trim;
    logic        [15:0] adc_trim;
    logic        [13:0] out_code;
    logic               reply_stb;
    logic        [15:0] reply_word;
    logic        [31:0] lfsr = 32'h0000_71ea;
    logic        [15:0] exp_q[$];
    int                 per = P;
    int                 err_count = 0;
    int                 n_tests = 0;

    // The pin follows the device while it drives, else the programmer.
    assign pin = out_pin_oe_n ? sel : out_pin_out;

    field_sensor_dsp_path #(.BIT_SHORT(P / 2), .BIT_LONG(P),
        .OSC_TRIM(16'h5a5a), .ADC_TRIM(16'h0c3c)) i_dut (
        .clk(clk), .rst(rst), .sample(sample), .sample_valid(sample_valid),
        .temperature(temperature), .adc_range(adc_range),
        .osc_trim(osc_trim), .adc_trim(adc_trim),
        .supply_in_band(supply_in_band), .supply_high(supply_high),
        .out_pin_in(pin), .out_pin_out(out_pin_out),
        .out_pin_oe_n(out_pin_oe_n), .analog_out_en(analog_out_en),
        .out_code(out_code), .factory_init(factory_init));
    prog_model i_prog (.clk(clk), .pin(pin), .oe_n(out_pin_oe_n),
        .in_band(supply_in_band), .high(supply_high), .sel(sel),
        .reply_stb(reply_stb), .reply_word(reply_word));

    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task check(input logic [15:0] seen, input logic [15:0] expv);
        n_tests++;
        if (seen !== expv) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d, input logic s);
        i_prog.frame(1'b1, a, d, s, per);
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_prog.frame(1'b0, a, 16'h0000, 1'b1, per);
    endtask
    task finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial forever #2 clk = ~clk;
    // Samples stay non-negative so a saturating sum is told from a wrap.
    always @(posedge clk) begin
        #1;
        lfsr = lfsr_step(lfsr);
        sample = {1'b0, lfsr[14:0]};
        sample_valid = lfsr[16];
        temperature = lfsr[27:20];
    end
    always @(posedge reply_stb) check(reply_word, exp_q.pop_front());

    // The memory has no reset, so it is loaded while reset is held; the
    // lock cell is then defined at the edge that captures it.
    initial begin
        repeat (18) @(posedge clk);
        #1;
        factory_init = 1'b1;
        @(posedge clk);
        #1;
        factory_init = 1'b0;
        @(posedge clk);
        #1;
        rst = 1'b0;
        // Bit 5 stays clear here, else the bit period would change under
        // the programmer in the middle of the loop.
        for (int r = 0; r < 4; r++) begin
            wr(field_sensor_pkg::ADDR_CONFIG, 16'((r << 2) | ((r & 1) << 4)),
               1'b1);
            check(16'(adc_range), 16'(r));
        end
        wr(field_sensor_pkg::ADDR_CONFIG, 16'h0020, 1'b1);
        per = P / 2;
        rd(field_sensor_pkg::ADDR_CONFIG, 16'h0020);
        wr(field_sensor_pkg::ADDR_CONFIG, 16'h0001, 1'b1);
        per = P;
        $display("config test done");
        wr(field_sensor_pkg::ADDR_GP_BASE, 16'h1abc, 1'b1);
        rd(field_sensor_pkg::ADDR_GP_BASE, 16'h1abc);
        wr(field_sensor_pkg::ADDR_CONFIG, 16'h0000, 1'b1);
        wr(field_sensor_pkg::ADDR_GP_BASE, 16'h0123, 1'b1);
        rd(field_sensor_pkg::ADDR_GP_BASE, 16'h1abc);
        wr(field_sensor_pkg::ADDR_TRIM_OSC, 16'h5555, 1'b1);
        check(osc_trim, 16'h5a5a);
        check(adc_trim, 16'h0c3c);
        fork
            rd(field_sensor_pkg::ADDR_CONFIG, 16'h0000);
            begin
                repeat (P) @(posedge clk);
                #1;
                check(16'(analog_out_en), 16'h0000);
            end
        join
        check(16'(analog_out_en), 16'h0001);
        $display("store and link test done");
        wr(field_sensor_pkg::ADDR_SENS, 16'h0000, 1'b1);
        wr(field_sensor_pkg::ADDR_QUIESCENT, 16'h1234, 1'b1);
        check(16'(out_code), 16'h1234);
        wr(field_sensor_pkg::ADDR_QUIESCENT, 16'h0400, 1'b0);
        check(16'(out_code), 16'h1234);
        wr(field_sensor_pkg::ADDR_CLAMP_HI, 16'h1000, 1'b1);
        check(16'(out_code), 16'h1000);
        wr(field_sensor_pkg::ADDR_CLAMP_LO, 16'h0800, 1'b1);
        wr(field_sensor_pkg::ADDR_QUIESCENT, 16'h0000, 1'b1);
        check(16'(out_code), 16'h0800);
        wr(field_sensor_pkg::ADDR_CLAMP_HI, 16'h3fff, 1'b1);
        wr(field_sensor_pkg::ADDR_QUIESCENT, 16'h7fff, 1'b1);
        wr(field_sensor_pkg::ADDR_SENS, 16'h7fff, 1'b1);
        check(16'(out_code), 16'h3fff);
        $display("signal path test done");
        wr(field_sensor_pkg::ADDR_LOCK, 16'h0001, 1'b1);
        wr(field_sensor_pkg::ADDR_CONFIG, 16'h0008, 1'b1);
        check(16'(adc_range), 16'h0002);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        wr(field_sensor_pkg::ADDR_CONFIG, 16'h000c, 1'b1);
        check(16'(adc_range), 16'h0002);
        check(16'(exp_q.size()), 16'h0000);
        $display("lock test done");
        finish_test();
    end

    // About 43000 cycles of frames are expected; the limit leaves margin.
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule
